// [design/osbe_pkg.sv]
package osbe_pkg;
  localparam int PC_W         = 11;
  localparam int DATA_W       = 8;
  localparam int REG_ADDR_W   = 7;
  localparam int SFR_ADDR_W   = 4;
  localparam int STACK_DEPTH  = 8;
  localparam int SP_W         = 3;
  localparam int SFR_COUNT    = 16;
  localparam int REG_COUNT    = 128;

  localparam logic [PC_W-1:0]       SWI_VECTOR    = 11'h001;
  localparam logic [PC_W-1:0]       PC_RESET      = 11'h000;
  localparam logic [DATA_W-1:0]     ACC_RESET     = 8'h00;
  localparam logic [DATA_W-1:0]     REG_RESET     = 8'h00;
  localparam logic [SP_W-1:0]       SP_RESET      = 3'h0;
  localparam logic [SFR_ADDR_W-1:0] SFR_LOW       = 4'h5;
  localparam logic [SFR_ADDR_W-1:0] SFR_HIGH      = 4'hF;

  // cycles per instruction class
  localparam logic [1:0] CYCLES_SINGLE = 2'h1;
  localparam logic [1:0] CYCLES_BRANCH = 2'h2;

  typedef enum logic [2:0] {
    OSBE_OP_NONE,
    OSBE_OP_SWI,
    OSBE_OP_OR_IMM,
    OSBE_OP_OR_REG,
    OSBE_OP_STORE_SEC,
    OSBE_OP_LOAD_SEC,
    OSBE_OP_LONG_JUMP,
    OSBE_OP_LONG_CALL
  } osbe_op_t;

  typedef struct packed {
    osbe_op_t              op;
    logic [DATA_W-1:0]     imm;
    logic [REG_ADDR_W-1:0] reg_addr;
    logic                  dest;
    logic [SFR_ADDR_W-1:0] sfr_addr;
    logic [PC_W-1:0]       target;
  } osbe_instr_t;

  typedef struct packed {
    logic [PC_W-1:0]   pc;
    logic [DATA_W-1:0] acc;
    logic              zero;
    logic [SP_W-1:0]   sp;
    logic [PC_W-1:0]   stack_top;
    logic              busy;
  } osbe_state_t;
endpackage

// [design/osbe_exec.sv]
// Function
// [RULE1] software interrupt pushes address of next instruction onto return stack
// [RULE2] software interrupt then loads vector 0x001 into PC[10:0]
// [RULE3] or-immediate ORs accumulator with 8-bit immediate, sets zero, one cycle
// [RULE4] or-register ORs accumulator with register 0..127, sets zero, one cycle
// [RULE5] destination bit 0 writes accumulator, 1 writes register back
// [RULE6] store-secondary copies accumulator to page register 5..15, flags kept, one cycle
// [RULE7] load-secondary copies page register 5..15 to accumulator, flags kept, one cycle
// [RULE8] long jump loads 11-bit target into PC, stack untouched, two cycles
// [RULE9] long call pushes next address, loads 11-bit target, two cycles, flags kept
// [RULE10] software interrupt takes two cycles; each push increments stack pointer
`timescale 1ns/10ps
`default_nettype none
module osbe_exec
  import osbe_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  input  wire logic        instr_valid_in,
  input  wire osbe_instr_t instr_in,
  output var  logic        instr_ready_out,
  output var  osbe_state_t state_out
);

  typedef enum logic {
    OSBE_ST_EXEC,
    OSBE_ST_SECOND
  } osbe_fsm_t;

  logic [PC_W-1:0]   pc_r;
  logic [DATA_W-1:0] acc_r;
  logic              zero_r;
  logic [SP_W-1:0]   sp_r;
  logic [PC_W-1:0]   stack_r [STACK_DEPTH];
  logic [DATA_W-1:0] regs_r  [REG_COUNT];
  logic [DATA_W-1:0] sfr_r   [SFR_COUNT];
  osbe_fsm_t         fsm_r;

  function automatic logic sfr_ok(input logic [SFR_ADDR_W-1:0] a);
    return (a >= SFR_LOW) && (a <= SFR_HIGH);
  endfunction

  function automatic logic [PC_W-1:0] next_pc(input logic [PC_W-1:0] p);
    return p + 11'h001;
  endfunction

  // two-cycle control transfers; the slot after them is dead
  function automatic logic is_branch(input osbe_op_t o);
    return (o == OSBE_OP_SWI) || (o == OSBE_OP_LONG_JUMP) || (o == OSBE_OP_LONG_CALL);
  endfunction

  // ops that leave a return address behind
  function automatic logic is_push(input osbe_op_t o);
    return (o == OSBE_OP_SWI) || (o == OSBE_OP_LONG_CALL);
  endfunction

  // the entry below the pointer is the last one pushed
  function automatic logic [SP_W-1:0] top_index(input logic [SP_W-1:0] p);
    return p - 3'h1;
  endfunction

  logic              take;
  logic [DATA_W-1:0] or_reg_val;
  logic [DATA_W-1:0] or_imm_val;

  // an op offered in the dead slot after a branch is dropped, not queued
  assign take       = instr_valid_in && (fsm_r == OSBE_ST_EXEC);
  assign or_reg_val = acc_r | regs_r[instr_in.reg_addr];
  assign or_imm_val = acc_r | instr_in.imm;

  // branches hold off the next instruction for one extra cycle
  // ready lives here so that it is low in the very cycle the slot is refused
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      fsm_r           <= OSBE_ST_EXEC;
      instr_ready_out <= 1'b1;
    end else begin
      unique case (fsm_r)
        OSBE_ST_EXEC: begin
          // [RULE8] [RULE9] [RULE10] two-cycle branches
          if (take && is_branch(instr_in.op)) begin
            fsm_r           <= OSBE_ST_SECOND;
            instr_ready_out <= 1'b0;
          end
        end
        OSBE_ST_SECOND: begin
          fsm_r           <= OSBE_ST_EXEC;
          instr_ready_out <= 1'b1;
        end
      endcase
    end
  end

  // program counter
  // pc is the address of the op being executed; fetch sits outside this block
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pc_r <= PC_RESET;
    end else if (take) begin
      unique case (instr_in.op)
        // [RULE2] vector load
        OSBE_OP_SWI:       pc_r <= SWI_VECTOR;
        // [RULE8] jump target
        OSBE_OP_LONG_JUMP: pc_r <= instr_in.target;
        // [RULE9] call target
        OSBE_OP_LONG_CALL: pc_r <= instr_in.target;
        default:           pc_r <= next_pc(pc_r);
      endcase
    end
  end

  // return stack storage; a ninth push overwrites the oldest level
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_r[i] <= PC_RESET;
      end
    end else if (take && is_push(instr_in.op)) begin
      // [RULE1] [RULE9] push return address
      stack_r[sp_r] <= next_pc(pc_r);
    end
  end

  // stack pointer; no overflow flag, software has to bound the call depth
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sp_r <= SP_RESET;
    end else if (take && is_push(instr_in.op)) begin
      // [RULE10] pointer increments
      sp_r <= sp_r + 3'h1;
    end
  end

  // accumulator
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      acc_r <= ACC_RESET;
    end else if (take) begin
      unique case (instr_in.op)
        OSBE_OP_OR_IMM: begin
          // [RULE3] or immediate
          acc_r <= or_imm_val;
        end
        OSBE_OP_OR_REG: begin
          // [RULE5] destination select
          if (!instr_in.dest) begin
            acc_r <= or_reg_val;
          end
        end
        OSBE_OP_LOAD_SEC: begin
          // [RULE7] load page register
          if (sfr_ok(instr_in.sfr_addr)) begin
            acc_r <= sfr_r[instr_in.sfr_addr];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // zero flag; page moves and branches leave it alone
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      zero_r <= 1'b0;
    end else if (take) begin
      unique case (instr_in.op)
        OSBE_OP_OR_IMM: begin
          // [RULE3] zero from result
          zero_r <= (or_imm_val == 8'h00);
        end
        OSBE_OP_OR_REG: begin
          // [RULE4] zero from result, either destination
          zero_r <= (or_reg_val == 8'h00);
        end
        default: begin
        end
      endcase
    end
  end

  // data-memory registers
  // a write-back lands at the taking edge, so the next op already sees it
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_r[i] <= REG_RESET;
      end
    end else if (take && instr_in.op == OSBE_OP_OR_REG && instr_in.dest) begin
      // [RULE5] write back to register
      regs_r[instr_in.reg_addr] <= or_reg_val;
    end
  end

  // secondary page registers; addresses below 5 are ignored
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < SFR_COUNT; i++) begin
        sfr_r[i] <= REG_RESET;
      end
    end else if (take && instr_in.op == OSBE_OP_STORE_SEC && sfr_ok(instr_in.sfr_addr)) begin
      // [RULE6] store accumulator
      sfr_r[instr_in.sfr_addr] <= acc_r;
    end
  end

  // outputs registered so state_out matches the architectural flops
  // the snapshot lags by one edge: a reader looks two edges after the issue edge
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_out <= '0;
    end else begin
      state_out.pc        <= pc_r;
      state_out.acc       <= acc_r;
      state_out.zero      <= zero_r;
      state_out.sp        <= sp_r;
      state_out.stack_top <= stack_r[top_index(sp_r)];
      state_out.busy      <= (fsm_r == OSBE_ST_SECOND);
    end
  end

endmodule
`default_nettype wire

// [verif/osbe_exec_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module osbe_exec_monitor
  import osbe_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        reset_in,
  input wire logic        instr_valid_in,
  input wire osbe_instr_t instr_in,
  input wire logic        instr_ready_out,
  input wire osbe_state_t state_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  osbe_state_t s;
  osbe_op_t    op;
  logic        is_br;
  assign s = state_out;
  assign is_br = op inside {OSBE_OP_SWI, OSBE_OP_LONG_JUMP, OSBE_OP_LONG_CALL};
  // an op offered while ready is low is dropped by the design
  assign op = (instr_valid_in && instr_ready_out) ? instr_in.op : OSBE_OP_NONE;
  // state_out trails the taking edge by two edges
  swi_push_a: assert property (op == OSBE_OP_SWI |-> ##2 s.pc == SWI_VECTOR
    && s.stack_top == $past(s.pc) + 11'h001) else $error("bad swi");
  swi_sp_a: assert property (op == OSBE_OP_SWI |-> ##2 s.sp == $past(s.sp) + 3'h1) else $error("bad sp");
  or_imm_a: assert property (op == OSBE_OP_OR_IMM |-> ##2 s.zero == (s.acc == 8'h00)
    && s.acc == ($past(s.acc) | $past(instr_in.imm, 2))) else $error("bad or imm");
  or_keep_a: assert property (op == OSBE_OP_OR_REG && instr_in.dest |-> ##2 s.acc == $past(s.acc))
    else $error("acc changed");
  or_zero_a: assert property (op == OSBE_OP_OR_REG && !instr_in.dest |-> ##2 s.zero == (s.acc == 8'h00))
    else $error("bad zero");
  sec_flags_a: assert property (op inside {OSBE_OP_STORE_SEC, OSBE_OP_LOAD_SEC} |-> ##2
    s.zero == $past(s.zero) && s.pc == $past(s.pc) + 11'h001) else $error("bad page move");
  jump_a: assert property (op == OSBE_OP_LONG_JUMP |-> ##2 s.pc == $past(instr_in.target, 2)
    && s.sp == $past(s.sp)) else $error("bad jump");
  call_a: assert property (op == OSBE_OP_LONG_CALL |-> ##2 s.pc == $past(instr_in.target, 2)
    && s.stack_top == $past(s.pc) + 11'h001) else $error("bad call");
  branch_slot_a: assert property (is_br |=> !instr_ready_out ##1 instr_ready_out)
    else $error("bad branch slot");
  single_slot_a: assert property (op inside {OSBE_OP_OR_IMM, OSBE_OP_OR_REG, OSBE_OP_STORE_SEC,
    OSBE_OP_LOAD_SEC} |=> instr_ready_out) else $error("single op stalled");
  cover property (op == OSBE_OP_SWI);
  cover property (op == OSBE_OP_LONG_JUMP);
  cover property (op == OSBE_OP_OR_REG && instr_in.dest);
  cover property (!instr_ready_out);
endmodule
bind osbe_exec osbe_exec_monitor i_osbe_exec_monitor (.clk_in(clk_in), .reset_in(reset_in),
  .instr_valid_in(instr_valid_in), .instr_in(instr_in), .instr_ready_out(instr_ready_out), .state_out(state_out));
`default_nettype wire

// [verif/osbe_exec_test.sv]
`timescale 1ns/10ps
`default_nettype none
module osbe_exec_test;
  import osbe_pkg::*;
  typedef struct packed {
    osbe_op_t    op;
    logic [10:0] arg;
    logic [33:0] exp;
  } osbe_row_t;
  logic        clk_in;
  logic        reset_in;
  logic        instr_valid_in;
  osbe_instr_t instr_in;
  logic        instr_ready_out;
  osbe_state_t state_out;
  int          errors;
  int          checked;
  // expected {pc, acc, zero, sp, stack_top}
  osbe_row_t rows [10] = '{
    '{OSBE_OP_OR_IMM, 11'h000, {11'h001, 8'h00, 1'h1, 3'h0, 11'h000}},
    '{OSBE_OP_OR_IMM, 11'h050, {11'h002, 8'h50, 1'h0, 3'h0, 11'h000}},
    '{OSBE_OP_OR_REG, 11'h083, {11'h003, 8'h50, 1'h0, 3'h0, 11'h000}},
    '{OSBE_OP_STORE_SEC, 11'h005, {11'h004, 8'h50, 1'h0, 3'h0, 11'h000}},
    '{OSBE_OP_LOAD_SEC, 11'h006, {11'h005, 8'h00, 1'h0, 3'h0, 11'h000}},
    '{OSBE_OP_OR_REG, 11'h003, {11'h006, 8'h50, 1'h0, 3'h0, 11'h000}},
    '{OSBE_OP_LONG_CALL, 11'h7FF, {11'h7FF, 8'h50, 1'h0, 3'h1, 11'h007}},
    '{OSBE_OP_SWI, 11'h000, {11'h001, 8'h50, 1'h0, 3'h2, 11'h000}},
    '{OSBE_OP_LONG_JUMP, 11'h123, {11'h123, 8'h50, 1'h0, 3'h2, 11'h000}},
    '{OSBE_OP_LOAD_SEC, 11'h005, {11'h124, 8'h50, 1'h0, 3'h2, 11'h000}}};
  osbe_exec i_osbe_exec (.clk_in(clk_in), .reset_in(reset_in), .instr_valid_in(instr_valid_in),
    .instr_in(instr_in), .instr_ready_out(instr_ready_out), .state_out(state_out));
  always #12.5 clk_in = ~clk_in;
  task automatic drive(input osbe_op_t op, input logic [10:0] a);
    instr_valid_in <= 1'h1;
    instr_in <= '{op, a[7:0], a[6:0], a[7], a[3:0], a};
  endtask
  // the idle edge after each issue keeps branches legal
  task automatic run(input osbe_op_t op, input logic [10:0] a);
    @(posedge clk_in);
    drive(op, a);
    @(posedge clk_in);
    instr_valid_in <= 1'h0;
    @(posedge clk_in);
    #1;
  endtask
  task automatic check(input string n, input logic [33:0] e, input logic [33:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic close_out();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #(400 * 25);
    errors++;
    close_out();
  end
  initial begin
    clk_in = 1'h0;
    reset_in = 1'h1;
    instr_valid_in = 1'h0;
    instr_in = '0;
    repeat (8) @(posedge clk_in);
    check("reset state", 34'h0, state_out[34:1]);
    reset_in <= 1'h0;
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].arg);
      check("row state", rows[i].exp, state_out[34:1]);
    end
    @(posedge clk_in);
    drive(OSBE_OP_OR_IMM, 11'h0AA);
    run(OSBE_OP_OR_IMM, 11'h005);
    check("back to back", {11'h126, 8'hFF, 1'h0, 3'h2, 11'h000}, state_out[34:1]);
    // reset in mid-run clears the state and reopens the issue slot
    @(posedge clk_in);
    reset_in <= 1'h1;
    repeat (2) @(posedge clk_in);
    #1;
    check("mid reset state", 34'h0, state_out[34:1]);
    check("mid reset ready", 34'h1, {33'h0, instr_ready_out});
    @(posedge clk_in);
    reset_in <= 1'h0;
    // an op held into the dead slot after a jump is dropped
    @(posedge clk_in);
    drive(OSBE_OP_LONG_JUMP, 11'h200);
    @(posedge clk_in);
    drive(OSBE_OP_OR_IMM, 11'h001);
    #1;
    check("dead slot ready", 34'h0, {33'h0, instr_ready_out});
    @(posedge clk_in);
    instr_valid_in <= 1'h0;
    #1;
    check("dead slot busy", 34'h1, {33'h0, state_out.busy});
    @(posedge clk_in);
    #1;
    check("dead slot state", {11'h200, 8'h00, 1'h0, 3'h0, 11'h000}, state_out[34:1]);
    close_out();
  end
endmodule
`default_nettype wire
